// >>> data_cache_block_ops.sv
`timescale 1ns/1ps
// What this block does
// - Base field zero selects a zero base
// - Otherwise base register plus index register
// - Allocate is opcode 31, extended 758
// - Allocate hit write-back keeps line valid
// - Allocate miss write-back allocates without fetch
// - Allocate write-through or uncachable does nothing
// - Allocate never faults; faults become no-op
// - Allocate counts as store everywhere
// - Flush is opcode 31, extended 86
// - Flush writes back modified, then invalidates
// - Flush ignores cachability; miss does nothing
// - Flush no-access zone fault, user relocated only
// - Flush/invalidate TLB miss when relocating
// - Flush load for access, store for compare
// - Invalidate is opcode 31, extended 470
// - Invalidate in user mode: program exception
// - Invalidate discards hit line, no write-back
// - Invalidate zone faults: no-access user, read-only
// - Invalidate faults on enabled user attribute
// - Invalidate counts as store everywhere
// - Reserved bits never raise program exception
module data_cache_block_ops (
  // Clock and reset
  input  wire logic                                   sys_clk_in,
  input  wire logic                                   rst_n_in,
  // Issue from the pipeline
  input  wire logic                                   issue_valid_in,
  input  wire logic [31:0]                            instr_in,
  input  wire logic [dcache_ops_pkg::addr_width-1:0]  base_value_in,
  input  wire logic [dcache_ops_pkg::addr_width-1:0]  index_value_in,
  input  wire logic                                   user_mode_in,
  input  wire logic                                   user_attr_exception_enable_in,
  output logic                                        issue_ready_out,
  // Register file read selects
  output logic [dcache_ops_pkg::gpr_sel_width-1:0]    base_register_field_out,
  output logic [dcache_ops_pkg::gpr_sel_width-1:0]    index_register_field_out,
  // Lookup of cache and translation
  output logic                                        lookup_valid_out,
  output logic [dcache_ops_pkg::addr_width-1:0]       effective_address_out,
  input  wire dcache_ops_pkg::line_status_t           line_status_in,
  input  wire dcache_ops_pkg::xlate_status_t          xlate_status_in,
  // Line actions to the arrays
  output dcache_ops_pkg::line_action_t                line_action_out,
  // Write-back to main memory
  output logic                                        wb_req_out,
  output logic [dcache_ops_pkg::addr_width-1:0]       wb_addr_out,
  input  wire logic                                   wb_ack_in,
  // Completion
  output logic                                        done_out,
  output dcache_ops_pkg::op_result_t                  result_out
);

  // Whole state of the block
  typedef struct packed {
    dcache_ops_pkg::seq_state_t                 state;
    dcache_ops_pkg::cache_op_t                  op;
    logic                                       user;
    logic                                       ue_enable;
    logic [dcache_ops_pkg::addr_width-1:0]      ea;
    dcache_ops_pkg::line_action_t               action;
    logic                                       wb_req;
    dcache_ops_pkg::op_result_t                 result;
    logic                                       done;
  } blk_state_t;

  blk_state_t state_reg;                        // Registered state
  blk_state_t state_next;                       // Next state

  // Decode fields of the incoming word
  logic [5:0]                                   opcd;
  logic [9:0]                                   xo;
  logic [dcache_ops_pkg::gpr_sel_width-1:0]     base_sel;
  dcache_ops_pkg::cache_op_t                    decoded_op;
  logic [dcache_ops_pkg::addr_width-1:0]        ea_calc;

  assign opcd     = instr_in[dcache_ops_pkg::opcd_msb:dcache_ops_pkg::opcd_lsb];
  assign xo       = instr_in[dcache_ops_pkg::xo_msb:dcache_ops_pkg::xo_lsb];
  assign base_sel = instr_in[dcache_ops_pkg::base_msb:dcache_ops_pkg::base_lsb];

  // Register file selects follow the instruction fields directly
  assign base_register_field_out  = base_sel;
  assign index_register_field_out = instr_in[dcache_ops_pkg::index_msb:dcache_ops_pkg::index_lsb];

  // Opcode decode; reserved bits and the record bit are not examined
  always_comb begin
    decoded_op = dcache_ops_pkg::op_none;
    if (opcd == dcache_ops_pkg::primary_opcode) begin
      case (xo)
        dcache_ops_pkg::xo_allocate:   decoded_op = dcache_ops_pkg::op_allocate;
        dcache_ops_pkg::xo_flush:      decoded_op = dcache_ops_pkg::op_flush;
        dcache_ops_pkg::xo_invalidate: decoded_op = dcache_ops_pkg::op_invalid;
        default:                       decoded_op = dcache_ops_pkg::op_none;
      endcase
    end
  end

  // Effective address; register zero reads as a literal zero base
  always_comb begin
    if (base_sel == dcache_ops_pkg::reg_zero) begin
      ea_calc = index_value_in;
    end else begin
      ea_calc = base_value_in + index_value_in;
    end
  end

  // Handshake and lookup outputs
  assign issue_ready_out       = (state_reg.state == dcache_ops_pkg::st_idle);
  assign lookup_valid_out      = (state_reg.state == dcache_ops_pkg::st_lookup);
  assign effective_address_out = state_reg.ea;
  // Data outputs straight from flops
  assign line_action_out       = state_reg.action;
  assign wb_req_out            = state_reg.wb_req;
  assign wb_addr_out           = state_reg.ea;
  assign done_out              = state_reg.done;
  assign result_out            = state_reg.result;

  // Sequencer
  always_comb begin
    logic tlb_miss;
    logic storage;
    tlb_miss   = 1'b0;
    storage    = 1'b0;
    state_next = state_reg;
    // Action and completion are one-cycle pulses
    state_next.action.valid      = 1'b0;
    state_next.action.allocate   = 1'b0;
    state_next.action.invalidate = 1'b0;
    state_next.done              = 1'b0;
    tlb_miss = xlate_status_in.relocate_on & ~xlate_status_in.tlb_match;
    case (state_reg.state)
      dcache_ops_pkg::st_idle: begin
        if (issue_valid_in && decoded_op != dcache_ops_pkg::op_none) begin
          state_next.op        = decoded_op;
          state_next.user      = user_mode_in;
          state_next.ue_enable = user_attr_exception_enable_in;
          state_next.ea        = ea_calc;
          state_next.result    = '0;
          // Classification stands for every outcome, the privilege trap included
          state_next.result.compare_as_store = 1'b1;
          state_next.result.access_as_store  = (decoded_op != dcache_ops_pkg::op_flush);
          state_next.action.address = ea_calc;
          // Privilege check needs no lookup
          if (decoded_op == dcache_ops_pkg::op_invalid && user_mode_in) begin
            state_next.result.program_exc = 1'b1;
            state_next.state = dcache_ops_pkg::st_done;
          end else begin
            state_next.state = dcache_ops_pkg::st_lookup;
          end
        end
      end
      dcache_ops_pkg::st_lookup: begin
        // Classification for access checks and debug compare
        state_next.result.compare_as_store = 1'b1;
        state_next.result.access_as_store  = (state_reg.op != dcache_ops_pkg::op_flush);
        state_next.state = dcache_ops_pkg::st_done;
        case (state_reg.op)
          dcache_ops_pkg::op_allocate: begin
            // Faulting conditions silently turn the allocate into a no-op
            if (!tlb_miss && !(xlate_status_in.relocate_on &&
                (xlate_status_in.zone_read_only || (state_reg.user && xlate_status_in.zone_no_access)))) begin
              // Only cachable write-back targets do anything
              if (line_status_in.cachable && line_status_in.write_back) begin
                if (!line_status_in.hit) begin
                  // Line allocated without a memory read; contents undefined
                  state_next.action.valid    = 1'b1;
                  state_next.action.allocate = 1'b1;
                end
                // Hit: line stays valid, nothing to do
              end
            end
          end
          dcache_ops_pkg::op_flush: begin
            storage = xlate_status_in.relocate_on & state_reg.user & xlate_status_in.zone_no_access;
            if (tlb_miss) begin
              state_next.result.tlb_miss_exc = 1'b1;
            end else if (storage) begin
              state_next.result.storage_exc = 1'b1;
            end else if (line_status_in.hit) begin
              if (line_status_in.modified) begin
                state_next.wb_req = 1'b1;
                state_next.state  = dcache_ops_pkg::st_writeback;
              end else begin
                state_next.action.valid      = 1'b1;
                state_next.action.invalidate = 1'b1;
              end
            end
          end
          dcache_ops_pkg::op_invalid: begin
            storage = (xlate_status_in.relocate_on &&
                       ((state_reg.user && xlate_status_in.zone_no_access) ||
                        xlate_status_in.zone_read_only)) ||
                      (xlate_status_in.user_attr && state_reg.ue_enable);
            if (tlb_miss) begin
              state_next.result.tlb_miss_exc = 1'b1;
            end else if (storage) begin
              state_next.result.storage_exc = 1'b1;
            end else if (line_status_in.hit) begin
              // Modified data is dropped on purpose, no write-back
              state_next.action.valid      = 1'b1;
              state_next.action.invalidate = 1'b1;
            end
          end
          default: state_next.state = dcache_ops_pkg::st_done;
        endcase
      end
      dcache_ops_pkg::st_writeback: begin
        // Hold until memory accepts, then drop the line
        if (wb_ack_in) begin
          state_next.wb_req            = 1'b0;
          state_next.action.valid      = 1'b1;
          state_next.action.invalidate = 1'b1;
          state_next.state             = dcache_ops_pkg::st_done;
        end
      end
      dcache_ops_pkg::st_done: begin
        // Reserved bits never feed the result
        state_next.done  = 1'b1;
        state_next.state = dcache_ops_pkg::st_idle;
      end
      default: state_next.state = dcache_ops_pkg::st_idle;
    endcase
  end

  // State register, synchronous reset
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : data_cache_block_ops

// >>> data_cache_block_ops_checker.sv
`timescale 1ns/1ps
module data_cache_block_ops_checker (
  // Clock, reset, issue
  input wire logic                          sys_clk_in,
  input wire logic                          rst_n_in,
  input wire logic                          issue_valid_in,
  input wire logic                          issue_ready_out,
  input wire logic [31:0]                   instr_in,
  input wire logic                          user_mode_in,
  input wire logic [31:0]                   base_value_in,
  input wire logic [31:0]                   index_value_in,
  // Lookup, actions, write-back, completion
  input wire logic                          lookup_valid_out,
  input wire logic [31:0]                   effective_address_out,
  input wire dcache_ops_pkg::line_status_t  line_status_in,
  input wire dcache_ops_pkg::line_action_t  line_action_out,
  input wire logic                          wb_req_out,
  input wire logic [31:0]                   wb_addr_out,
  input wire logic                          wb_ack_in,
  input wire logic                          done_out,
  input wire dcache_ops_pkg::op_result_t    result_out
);
  wire logic [9:0] xo = instr_in[10:1]; // Extended opcode
  wire logic take = issue_valid_in && issue_ready_out && instr_in[31:26] == 6'h1f &&
    (xo == 10'h2f6 || xo == 10'h056 || xo == 10'h1d6); // Accepted operation
  logic [9:0] xo_reg; // Operation in flight
  // Remember which operation was taken
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) xo_reg <= 10'h000;
    else if (take) xo_reg <= xo;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_lookup_follows: assert property (take && !(xo == 10'h1d6 && user_mode_in) |=> lookup_valid_out)
    else $error("no lookup after take");
  a_ea_zero_base: assert property (take && instr_in[20:16] == 5'h00 |=> effective_address_out == $past(index_value_in))
    else $error("zero base not used");
  a_ea_sum_base: assert property (take && instr_in[20:16] != 5'h00 |=>
    effective_address_out == $past(base_value_in) + $past(index_value_in))
    else $error("address sum wrong");
  a_priv_trap: assert property (take && xo == 10'h1d6 && user_mode_in |=> !lookup_valid_out ##1
    done_out && result_out.program_exc)
    else $error("user invalidate not trapped");
  a_alloc_no_fault: assert property (take && xo == 10'h2f6 |-> ##2 !result_out.storage_exc &&
    !result_out.tlb_miss_exc && result_out.access_as_store && result_out.compare_as_store)
    else $error("allocate faulted");
  a_flush_as_load: assert property (take && xo == 10'h056 |-> ##2
    !result_out.access_as_store && result_out.compare_as_store)
    else $error("flush class wrong");
  a_wb_held: assert property (wb_req_out && !wb_ack_in |=> wb_req_out && $stable(wb_addr_out))
    else $error("write-back dropped early");
  a_wb_then_inval: assert property (wb_req_out && wb_ack_in |=> line_action_out.valid &&
    line_action_out.invalidate && line_action_out.address == $past(wb_addr_out) ##1 done_out)
    else $error("no invalidate after write-back");
  a_wt_no_alloc: assert property (lookup_valid_out && !line_status_in.write_back |=>
    !(line_action_out.valid && line_action_out.allocate))
    else $error("allocate under write-through");
  a_inv_no_wb: assert property (lookup_valid_out && xo_reg == 10'h1d6 |=> !wb_req_out)
    else $error("invalidate wrote back");
  a_miss_idle: assert property (lookup_valid_out && xo_reg != 10'h2f6 && !line_status_in.hit |=>
    !line_action_out.valid && !wb_req_out)
    else $error("miss caused action");
endmodule : data_cache_block_ops_checker

bind data_cache_block_ops data_cache_block_ops_checker i_data_cache_block_ops_checker (.sys_clk_in, .rst_n_in,
  .issue_valid_in, .issue_ready_out, .instr_in, .user_mode_in, .base_value_in, .index_value_in, .lookup_valid_out,
  .effective_address_out, .line_status_in, .line_action_out, .wb_req_out, .wb_addr_out, .wb_ack_in, .done_out,
  .result_out);

// >>> dcache_ops_pkg.sv
package dcache_ops_pkg;

  // Instruction word fields (bit 31 is the most significant bit)
  localparam logic [5:0] primary_opcode   = 6'h1f;   // 31
  localparam logic [9:0] xo_allocate      = 10'h2f6; // 758
  localparam logic [9:0] xo_flush         = 10'h056; // 86
  localparam logic [9:0] xo_invalidate    = 10'h1d6; // 470
  localparam int         opcd_msb         = 31;
  localparam int         opcd_lsb         = 26;
  localparam int         base_msb         = 20;
  localparam int         base_lsb         = 16;
  localparam int         index_msb        = 15;
  localparam int         index_lsb        = 11;
  localparam int         xo_msb           = 10;
  localparam int         xo_lsb           = 1;

  // Widths
  localparam int         addr_width       = 32;
  localparam int         gpr_sel_width    = 5;
  localparam logic [4:0] reg_zero         = 5'h00;

  // Operation kinds
  typedef enum logic [1:0] {
    op_none     = 2'b00,
    op_allocate = 2'b01,
    op_flush    = 2'b10,
    op_invalid  = 2'b11
  } cache_op_t;

  // Sequencer states
  typedef enum logic [1:0] {
    st_idle      = 2'b00,
    st_lookup    = 2'b01,
    st_writeback = 2'b10,
    st_done      = 2'b11
  } seq_state_t;

  // Cache lookup answer for the effective address
  typedef struct packed {
    logic hit;
    logic modified;
    logic cachable;
    logic write_back;
  } line_status_t;

  // Translation and protection answer
  typedef struct packed {
    logic relocate_on;
    logic tlb_match;
    logic zone_no_access;
    logic zone_read_only;
    logic user_attr;
  } xlate_status_t;

  // Action sent to the cache arrays
  typedef struct packed {
    logic                  valid;
    logic                  allocate;
    logic                  invalidate;
    logic [addr_width-1:0] address;
  } line_action_t;

  // Exception and debug outcome
  typedef struct packed {
    logic program_exc;
    logic storage_exc;
    logic tlb_miss_exc;
    logic compare_as_store;
    logic access_as_store;
  } op_result_t;

endpackage : dcache_ops_pkg

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [4:0]  res;      // Result flags
    logic        inv;      // Invalidate action
    logic        alc;      // Allocate action
    logic        alc_care; // Allocate bit judged
    logic        wb;       // Write-back
    logic [31:0] ea;       // Target address
  } note_t;
  logic sys_clk_in, rst_n_in, issue_valid_in, user_mode_in, user_attr_exception_enable_in, issue_ready_out;
  logic lookup_valid_out, wb_req_out, wb_ack_in, done_out;
  logic [31:0] instr_in, base_value_in, index_value_in, effective_address_out, wb_addr_out, seen_addr;
  logic [7:0] ack_delay; // Memory pacing
  logic [4:0] base_sel_seen, index_sel_seen; // Register file selects
  dcache_ops_pkg::line_status_t line_status_in;
  dcache_ops_pkg::xlate_status_t xlate_status_in;
  dcache_ops_pkg::line_action_t line_action_out;
  dcache_ops_pkg::op_result_t result_out;
  note_t notes[$];
  note_t nt;
  logic seen_inv, seen_alc, seen_wb;
  integer seed = 32'hc2214dcd;
  int n_fail = 0;
  int n_checks = 0;
  data_cache_block_ops i_data_cache_block_ops (.sys_clk_in, .rst_n_in, .issue_valid_in, .instr_in,
    .base_value_in, .index_value_in, .user_mode_in, .user_attr_exception_enable_in, .issue_ready_out,
    .base_register_field_out(base_sel_seen), .index_register_field_out(index_sel_seen), .lookup_valid_out,
    .effective_address_out,
    .line_status_in, .xlate_status_in, .line_action_out, .wb_req_out, .wb_addr_out, .wb_ack_in, .done_out,
    .result_out);
  wb_memory_model i_wb_memory_model (.sys_clk_in, .rst_n_in, .wb_req_in(wb_req_out), .ack_delay_in(ack_delay),
    .wb_ack_out(wb_ack_in));
  // 40 MHz clock
  always #12.5 sys_clk_in = ~sys_clk_in;
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic check(input logic [39:0] e, input logic [39:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : check
  // Expected outcome from the current inputs
  function automatic note_t expect_op(input logic [9:0] xo, input logic [31:0] ea);
    note_t n;
    dcache_ops_pkg::xlate_status_t x;
    dcache_ops_pkg::line_status_t l;
    logic u, prg, tlb, sto, af;
    x = xlate_status_in;
    l = line_status_in;
    u = user_mode_in;
    prg = xo == 10'h1d6 && u;
    tlb = !prg && xo != 10'h2f6 && x.relocate_on && !x.tlb_match;
    sto = !prg && !tlb && (xo == 10'h056 ? x.relocate_on && u && x.zone_no_access : xo == 10'h1d6 &&
      (x.relocate_on && (u && x.zone_no_access || x.zone_read_only) || x.user_attr && user_attr_exception_enable_in));
    af = x.relocate_on && (!x.tlb_match || x.zone_read_only || u && x.zone_no_access);
    n.res = {prg, sto, tlb, 1'b1, xo != 10'h056};
    n.inv = !prg && !tlb && !sto && xo != 10'h2f6 && l.hit;
    n.wb = n.inv && xo == 10'h056 && l.modified;
    n.alc = xo == 10'h2f6 && !af && l.cachable && l.write_back && !l.hit;
    n.alc_care = !(xo == 10'h2f6 && l.hit); // Hit keeps line either way
    n.ea = ea;
    return n;
  endfunction : expect_op
  // Issue one operation and wait for its completion
  task automatic issue(input int k);
    logic [9:0] xo;
    logic [31:0] w, r;
    int t;
    xo = (k == 0) ? 10'h2f6 : (k == 1) ? 10'h056 : 10'h1d6;
    w = $random(seed); // Random fields and reserved bits
    r = $random(seed);
    w[31:26] = 6'h1f;
    w[10:1] = xo;
    if (w[0]) w[20:16] = 5'h00; // Favour a zero base field
    instr_in = w;
    base_value_in = $random(seed);
    index_value_in = $random(seed);
    {xlate_status_in, line_status_in, user_attr_exception_enable_in, user_mode_in} = r[10:0];
    ack_delay = {5'h00, r[13:11]};
    notes.push_back(expect_op(xo, (w[20:16] == 5'h00 ? 32'h0 : base_value_in) + index_value_in));
    issue_valid_in = 1'b1;
    t = 0;
    while (issue_ready_out !== 1'b1) begin @(posedge sys_clk_in); #1; end
    @(posedge sys_clk_in);
    #1 issue_valid_in = 1'b0;
    check({30'h0, w[20:16], w[15:11]}, {30'h0, base_sel_seen, index_sel_seen});
    while (done_out !== 1'b1 && t < 40) begin @(posedge sys_clk_in); #1; t++; end
    if (t == 40) check(40'h1, {39'h0, done_out});
  endtask : issue
  // Gather action and write-back, judge at done
  always @(posedge sys_clk_in) begin
    if (line_action_out.valid === 1'b1) {seen_alc, seen_inv, seen_addr} = line_action_out[33:0];
    if (wb_req_out === 1'b1) {seen_wb, seen_addr} = {1'b1, wb_addr_out};
    if (done_out === 1'b1) begin
      nt = (notes.size() > 0) ? notes.pop_front() : '1; // Surplus completion always mismatches
      check({nt.res, nt.inv, nt.alc & nt.alc_care, nt.wb, nt.ea & {32{nt.inv | nt.alc | nt.wb}}},
        {result_out, seen_inv, seen_alc & nt.alc_care, seen_wb, seen_addr});
      {seen_inv, seen_alc, seen_wb, seen_addr} = '0;
    end
  end
  // Reset, an ignored word, then random operations
  initial begin
    {sys_clk_in, rst_n_in, issue_valid_in, user_mode_in, user_attr_exception_enable_in} = '0;
    {instr_in, base_value_in, index_value_in, line_status_in, xlate_status_in, ack_delay} = '0;
    {seen_inv, seen_alc, seen_wb, seen_addr} = '0;
    repeat (16) @(posedge sys_clk_in);
    #1 rst_n_in = 1'b1;
    instr_in = {6'h1f, 15'h0000, 10'h036, 1'b0}; // Not one of ours: no completion
    issue_valid_in = 1'b1;
    repeat (6) @(posedge sys_clk_in);
    #1 issue_valid_in = 1'b0;
    for (int i = 0; i < 300; i++) issue(i % 3);
    repeat (8) @(posedge sys_clk_in);
    stop_test();
  end
  // Watchdog well past 300 slow operations
  initial begin
    #(25 * 20000);
    n_fail++;
    stop_test();
  end
endmodule : tb_top

// >>> wb_memory_model.sv
`timescale 1ns/1ps
module wb_memory_model (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // Write-back request and pacing
  input  wire logic        wb_req_in,
  input  wire logic [7:0]  ack_delay_in,
  output logic             wb_ack_out
);
  logic [7:0] wait_reg; // Cycles the request has waited
  // Accept after a chosen delay; one-cycle ack, low otherwise
  always @(posedge sys_clk_in) begin
    if (!rst_n_in || !wb_req_in || wb_ack_out) begin
      wait_reg   <= 8'h00;
      wb_ack_out <= 1'b0;
    end else begin
      wait_reg   <= wait_reg + 8'h01;
      wb_ack_out <= (wait_reg >= ack_delay_in);
    end
  end
endmodule : wb_memory_model
